// *** rtl/dmp_group_asm.sv ***
/*
 * Group assembler: packs five bytes of a defect group into cylinder,
 * offset and flags, pulsing valid the cycle after the fifth byte.
 * Assumes byteEn marks group bytes only and start clears the phase.
 */
`timescale 1ns/1ns
`default_nettype none

module dmp_group_asm (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // Byte stream
    input  wire logic       start,
    input  wire logic       byteEn,
    input  wire logic [7:0] byteIn,
    // Assembled group
    dmp_group_if.source     grp
);

    logic [2:0]  phase_reg;
    logic [31:0] shift_reg;
    logic        ones_reg;
    logic        lastByte;

    // Fifth byte of a group closes it
    assign lastByte = byteEn && (phase_reg == 3'(dmp_pkg::GROUP_BYTES - 1));

    // Byte phase and assembly
    always_ff @(posedge clk) begin
        if (!reset_n || start) begin
            phase_reg <= 3'h0;
            shift_reg <= 32'h0000_0000;
            ones_reg  <= 1'b1;
        end else if (byteEn) begin
            phase_reg <= lastByte ? 3'h0 : phase_reg + 3'h1;
            // RULE_06 field order
            if (!lastByte) begin
                shift_reg <= {shift_reg[23:0], byteIn};
            end
            // RULE_07 all-ones check
            ones_reg  <= lastByte ? 1'b1 : (ones_reg && byteIn == dmp_pkg::ALL_ONES);
        end
    end

    // Output group, one-cycle valid
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            grp.valid    <= 1'b0;
            grp.cylinder <= 16'h0000;
            grp.offset   <= 16'h0000;
            grp.allOnes  <= 1'b0;
            grp.padError <= 1'b0;
        end else begin
            grp.valid <= lastByte && !start;
            if (lastByte) begin
                // RULE_06 cylinder then offset
                grp.cylinder <= shift_reg[31:16];
                grp.offset   <= shift_reg[15:0];
                grp.allOnes  <= ones_reg && byteIn == dmp_pkg::ALL_ONES;
                grp.padError <= byteIn != 8'h00;
            end
        end
    end

endmodule : dmp_group_asm

`default_nettype wire

// *** rtl/dmp_group_if.sv ***
/*
 * Interface carrying one assembled five-byte group from the group
 * assembler to the parser top. Assumes a single clock domain.
 */
`timescale 1ns/1ns
`default_nettype none

interface dmp_group_if;
    logic        valid;
    logic [15:0] cylinder;
    logic [15:0] offset;
    logic        allOnes;
    logic        padError;

    modport source (output valid, output cylinder, output offset, output allOnes, output padError);
    modport sink   (input valid, input cylinder, input offset, input allOnes, input padError);
endinterface : dmp_group_if

`default_nettype wire

// *** rtl/dmp_parser.sv ***
/*
 * Defect map parser top. Takes the 256 bytes of one list sector and
 * emits the header fields and one record per defect group.
 * Assumes the host controller delivers the right sector, one byte per
 * enabled cycle, and raises sectorStart before the first byte.
 */
// Behaviour
// [RULE_01] List for a surface is read only from that surface's sectors.
// [RULE_02] Copies sit in sector zero of track zero, max, and max minus eight.
// [RULE_03] List sectors are 32 sectors of 256 bytes, no interleave.
// [RULE_04] Six header bytes: month, day, year, head, two zero pads.
// [RULE_05] Then 250 bytes form 50 five-byte groups.
// [RULE_06] Group: cylinder high, low, offset high, low, zero byte.
// [RULE_07] List ends after 50 groups or at first all-ones group.
// [RULE_08] Defect under two bytes is single, otherwise multiple.
// [RULE_09] On a check error, try the next redundant copy first.
`timescale 1ns/1ns
`default_nettype none

module dmp_parser #(
    parameter int unsigned CYL_W = 16
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // Copy location request
    input  wire logic [15:0]      maxTrack,
    input  wire logic [1:0]       copySel,
    output logic [15:0]           copyTrack,
    // Sector byte stream from host
    input  wire logic             sectorStart,
    input  wire logic             byteValid,
    input  wire logic [7:0]       byteData,
    // Header fields
    output logic [7:0]            recMonth,
    output logic [7:0]            recDay,
    output logic [7:0]            recYear,
    output logic [7:0]            recHead,
    output logic                  headerError,
    // Defect records
    output logic                  defectValid,
    output logic [CYL_W-1:0]      defectCylinder,
    output logic [15:0]           defectOffset,
    output logic                  groupError,
    // Status
    output logic                  listDone,
    output logic [5:0]            defectCount
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    dmp_pkg::dmp_state_e state_reg;
    dmp_pkg::dmp_state_e state_next;
    logic [7:0]  byteIdx_reg;
    logic [5:0]  groupIdx_reg;
    logic        groupByte;
    logic        headerByte;
    logic        sectorEnd;
    logic        groupsDone;
    logic        terminator;
    logic [15:0] trackSel;

    dmp_group_if grpBus ();

    // ------------------------------------------------------------
    // Copy location
    // ------------------------------------------------------------

    // RULE_02 redundant copy tracks
    assign trackSel = (copySel == dmp_pkg::COPY_MAX)   ? maxTrack :
                      (copySel == dmp_pkg::COPY_MAXM8) ? maxTrack - 16'(dmp_pkg::SPARE_OFFSET) :
                      16'h0000;

    // Registered track for the host, sector is always zero
    // RULE_01 copy on this surface
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            copyTrack <= 16'h0000;
        end else begin
            copyTrack <= trackSel;
        end
    end

    // ------------------------------------------------------------
    // Byte position decode
    // ------------------------------------------------------------

    // RULE_03 fixed 256-byte sector
    assign sectorEnd  = byteValid && byteIdx_reg == dmp_pkg::LAST_BYTE;
    // RULE_04 first six bytes are header
    assign headerByte = byteValid && state_reg == dmp_pkg::DMP_HEADER;
    // RULE_05 groups follow the header
    assign groupByte  = byteValid && state_reg == dmp_pkg::DMP_GROUPS;
    assign groupsDone = grpBus.valid && groupIdx_reg == 6'(dmp_pkg::GROUP_COUNT - 1);
    // RULE_07 all-ones terminator
    assign terminator = grpBus.valid && grpBus.allOnes;

    // Byte counter within the sector
    always_ff @(posedge clk) begin
        if (!reset_n || sectorStart) begin
            byteIdx_reg <= 8'h00;
        end else if (byteValid) begin
            byteIdx_reg <= byteIdx_reg + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Parser state machine
    // ------------------------------------------------------------

    // Next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            dmp_pkg::DMP_HEADER: begin
                if (headerByte && byteIdx_reg == 8'(dmp_pkg::HEADER_BYTES - 1)) begin
                    state_next = dmp_pkg::DMP_GROUPS;
                end
            end
            dmp_pkg::DMP_GROUPS: begin
                // RULE_07 end of list
                if (terminator || groupsDone) begin
                    state_next = dmp_pkg::DMP_SKIP;
                end
            end
            dmp_pkg::DMP_SKIP: begin
                state_next = dmp_pkg::DMP_SKIP;
            end
            default: begin
                state_next = dmp_pkg::DMP_HEADER;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk) begin
        if (!reset_n || sectorStart) begin
            state_reg <= dmp_pkg::DMP_HEADER;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Header capture
    // ------------------------------------------------------------

    // RULE_04 header field capture
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            recMonth    <= 8'h00;
            recDay      <= 8'h00;
            recYear     <= 8'h00;
            recHead     <= 8'h00;
            headerError <= 1'b0;
        end else if (sectorStart) begin
            headerError <= 1'b0;
        end else if (headerByte) begin
            case (byteIdx_reg)
                dmp_pkg::HDR_MONTH: recMonth <= byteData;
                dmp_pkg::HDR_DAY:   recDay   <= byteData;
                dmp_pkg::HDR_YEAR:  recYear  <= byteData;
                dmp_pkg::HDR_HEAD:  recHead  <= byteData;
                default: begin
                    // Pad bytes must be zero
                    if (byteData != 8'h00) begin
                        headerError <= 1'b1;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Group assembly
    // ------------------------------------------------------------

    // RULE_05 five-byte groups
    dmp_group_asm u_asm (
        .clk     (clk),
        .reset_n (reset_n),
        .start   (sectorStart),
        .byteEn  (groupByte),
        .byteIn  (byteData),
        .grp     (grpBus.source)
    );

    // ------------------------------------------------------------
    // Defect output and status
    // ------------------------------------------------------------

    // Group counter
    always_ff @(posedge clk) begin
        if (!reset_n || sectorStart) begin
            groupIdx_reg <= 6'h00;
        end else if (grpBus.valid && state_reg == dmp_pkg::DMP_GROUPS) begin
            groupIdx_reg <= groupIdx_reg + 6'h01;
        end
    end

    // RULE_06 emit defect record
    always_ff @(posedge clk) begin
        if (!reset_n || sectorStart) begin
            defectValid    <= 1'b0;
            defectCylinder <= '0;
            defectOffset   <= 16'h0000;
            groupError     <= 1'b0;
            defectCount    <= 6'h00;
            listDone       <= 1'b0;
        end else begin
            defectValid <= grpBus.valid && !grpBus.allOnes && state_reg == dmp_pkg::DMP_GROUPS;
            if (grpBus.valid && !grpBus.allOnes && state_reg == dmp_pkg::DMP_GROUPS) begin
                defectCylinder <= CYL_W'(grpBus.cylinder);
                defectOffset   <= grpBus.offset;
                groupError     <= grpBus.padError;
                defectCount    <= defectCount + 6'h01;
            end
            // RULE_07 list complete at sector end
            if (sectorEnd) begin
                listDone <= 1'b1;
            end
        end
    end

endmodule : dmp_parser

`default_nettype wire

// *** rtl/dmp_pkg.sv ***
/*
 * Package for the defect map parser: sector layout constants and states.
 * Assumes nothing of its surroundings.
 */
package dmp_pkg;

    // ------------------------------------------------------------
    // Sector layout
    // ------------------------------------------------------------
    localparam int unsigned SECTOR_BYTES  = 256;
    localparam int unsigned HEADER_BYTES  = 6;
    localparam int unsigned GROUP_BYTES   = 5;
    localparam int unsigned GROUP_COUNT   = 50;
    localparam int unsigned SECT_PER_TRK  = 32;
    localparam int unsigned SPARE_OFFSET  = 8;

    // Header byte positions and last sector byte
    localparam logic [7:0] HDR_MONTH = 8'h00;
    localparam logic [7:0] HDR_DAY   = 8'h01;
    localparam logic [7:0] HDR_YEAR  = 8'h02;
    localparam logic [7:0] HDR_HEAD  = 8'h03;
    localparam logic [7:0] LAST_BYTE = 8'hFF;

    // Terminator byte pattern
    localparam logic [7:0] ALL_ONES = 8'hFF;

    // Copy selector codes
    localparam logic [1:0] COPY_TRK0  = 2'h0;
    localparam logic [1:0] COPY_MAX   = 2'h1;
    localparam logic [1:0] COPY_MAXM8 = 2'h2;

    // ------------------------------------------------------------
    // Parser states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DMP_HEADER,
        DMP_GROUPS,
        DMP_SKIP
    } dmp_state_e;

endpackage : dmp_pkg

// *** verification/dmp_host_model.sv ***
/* Host controller model: streams one stored list sector.
   Bench fills mem and calls send; drives on falling edges. */
`timescale 1ns/1ns
`default_nettype none
module dmp_host_model (
    // Clock
    input  wire logic  clk,
    // Sector byte stream
    output logic       sectorStart,
    output logic       byteValid,
    output logic [7:0] byteData
);
    logic [7:0] mem [256];
    initial begin
        sectorStart = 1'b0;
        byteValid = 1'b0;
        byteData = 8'h00;
    end
    task send(input logic slowMode);
        @(negedge clk);
        sectorStart = 1'b1;
        @(negedge clk);
        sectorStart = 1'b0;
        for (int i = 0; i < 256; i++) begin
            if (slowMode) begin
                byteValid = 1'b0;
                byteData = ~byteData;
                @(negedge clk);
            end
            byteValid = 1'b1;
            byteData = mem[i];
            @(negedge clk);
        end
        byteValid = 1'b0;
        byteData = ~byteData;
    endtask : send
endmodule : dmp_host_model
`default_nettype wire

// *** verification/dmp_parser_sva.sv ***
/* Concurrent checks on the defect map parser ports.
   Bound to every dmp_parser; one clock, synchronous reset. */
`timescale 1ns/1ns
`default_nettype none
module dmp_parser_sva #(
    parameter int unsigned CYL_W = 16
) (
    // Clock and reset
    input wire logic             clk,
    input wire logic             reset_n,
    // Copy location
    input wire logic [15:0]      maxTrack,
    input wire logic [1:0]       copySel,
    input wire logic [15:0]      copyTrack,
    // Byte stream
    input wire logic             sectorStart,
    input wire logic             byteValid,
    input wire logic [7:0]       byteData,
    // Header and records
    input wire logic [7:0]       recMonth,
    input wire logic [7:0]       recDay,
    input wire logic [7:0]       recYear,
    input wire logic [7:0]       recHead,
    input wire logic             headerError,
    input wire logic             defectValid,
    input wire logic [CYL_W-1:0] defectCylinder,
    input wire logic [15:0]      defectOffset,
    input wire logic             groupError,
    input wire logic             listDone,
    input wire logic [5:0]       defectCount
);
    logic [8:0]  idx;
    logic [31:0] sh;
    logic        term;
    // Byte position decode
    wire tk = byteValid && !sectorStart;
    wire fifth = tk && idx >= 9'h00A && idx <= 9'h0FF && (idx - 9'h00A) % 9'h005 == 9'h000;
    wire ones = {sh, byteData} == 40'hFFFFFFFFFF;
    wire emit = fifth && !term && !ones;
    wire [15:0] cpExp = copySel == 2'h1 ? maxTrack : copySel == 2'h2 ? maxTrack - 16'h0008 : 16'h0000;
    // Byte index, last four bytes, terminator seen
    always_ff @(posedge clk) begin
        if (!reset_n || sectorStart) begin
            idx  <= 9'h000;
            term <= 1'b0;
        end else if (tk) begin
            idx  <= idx + 9'h001;
            sh   <= {sh[23:0], byteData};
            term <= term || (fifth && ones);
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_emit;
        emit;
    endsequence
    a_month_capture: assert property (tk && idx == 9'h000 |=> recMonth == $past(byteData))
        else $error("month byte not captured");
    a_head_capture: assert property (tk && idx == 9'h003 |=> recHead == $past(byteData))
        else $error("head byte not captured");
    a_pad_error: assert property (tk && idx inside {9'h004, 9'h005} && byteData != 8'h00 |=> headerError)
        else $error("nonzero pad not flagged");
    a_start_clears: assert property (sectorStart |=> !headerError && !listDone && defectCount == 6'h00)
        else $error("sector start did not clear status");
    a_record_emit: assert property (s_emit |-> ##2 defectValid && defectCylinder == $past(sh[31:16], 2)
        && defectOffset == $past(sh[15:0], 2)) else $error("defect record wrong or missing");
    a_group_error: assert property (s_emit |-> ##2 groupError == ($past(byteData, 2) != 8'h00))
        else $error("group error wrong");
    a_no_spurious: assert property (defectValid |-> $past(emit, 2))
        else $error("record without a defect group");
    a_count_step: assert property (defectValid |-> defectCount == $past(defectCount) + 6'h01)
        else $error("defect count did not step");
    a_list_done: assert property (tk && idx == 9'h0FF |=> listDone)
        else $error("list end not flagged");
    a_copy_track: assert property ($past(reset_n) |-> copyTrack == $past(cpExp))
        else $error("copy track wrong");
endmodule : dmp_parser_sva
bind dmp_parser dmp_parser_sva #(.CYL_W(CYL_W)) dmp_parser_sva_inst (
    .clk            (clk),
    .reset_n        (reset_n),
    .maxTrack       (maxTrack),
    .copySel        (copySel),
    .copyTrack      (copyTrack),
    .sectorStart    (sectorStart),
    .byteValid      (byteValid),
    .byteData       (byteData),
    .recMonth       (recMonth),
    .recDay         (recDay),
    .recYear        (recYear),
    .recHead        (recHead),
    .headerError    (headerError),
    .defectValid    (defectValid),
    .defectCylinder (defectCylinder),
    .defectOffset   (defectOffset),
    .groupError     (groupError),
    .listDone       (listDone),
    .defectCount    (defectCount)
);
`default_nettype wire

// *** verification/test_defect_map_parser.sv ***
/* Self-checking bench for the defect map parser.
   Needs the host model and the bound checker. */
`timescale 1ns/1ns
`default_nettype none
module test_defect_map_parser;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [15:0] maxTrack = 16'h03FF;
    logic [1:0]  copySel = 2'h0;
    logic [15:0] copyTrack, defectCylinder, defectOffset;
    logic        sectorStart, byteValid, headerError, defectValid, groupError, listDone;
    logic [7:0]  byteData, recMonth, recDay, recYear, recHead;
    logic [5:0]  defectCount;
    logic [32:0] recQ[$];
    int          num_errors = 0;
    int          checks = 0;
    int          cycles = 0;
    dmp_parser dmp_parser_inst (
        .clk            (clk),
        .reset_n        (reset_n),
        .maxTrack       (maxTrack),
        .copySel        (copySel),
        .copyTrack      (copyTrack),
        .sectorStart    (sectorStart),
        .byteValid      (byteValid),
        .byteData       (byteData),
        .recMonth       (recMonth),
        .recDay         (recDay),
        .recYear        (recYear),
        .recHead        (recHead),
        .headerError    (headerError),
        .defectValid    (defectValid),
        .defectCylinder (defectCylinder),
        .defectOffset   (defectOffset),
        .groupError     (groupError),
        .listDone       (listDone),
        .defectCount    (defectCount)
    );
    dmp_host_model dmp_host_model_inst (
        .clk         (clk),
        .sectorStart (sectorStart),
        .byteValid   (byteValid),
        .byteData    (byteData)
    );
    always #20 clk = ~clk;
    // Record capture off the launching edge, and hang guard
    always @(negedge clk) begin
        cycles++;
        if (defectValid) recQ.push_back({groupError, defectCylinder, defectOffset});
        if (cycles == 4000) begin
            num_errors++;
            end_of_test();
        end
    end
    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task end_of_test;
        $display("Errors %0d, checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_of_test
    // Sector image: header, defects, optional terminator, filler
    task build(input int nDef, input logic term, input logic [7:0] pad);
        logic [7:0] img [256];
        int         b;
        for (int i = 0; i < 256; i++) img[i] = 8'h12;
        img[0] = 8'h0C;
        img[1] = 8'h1F;
        img[2] = 8'h57;
        img[3] = 8'h03;
        img[4] = 8'h00;
        img[5] = pad;
        for (int i = 0; i < nDef; i++) begin
            b = 6 + 5 * i;
            img[b]     = i[7:0];
            img[b + 1] = 8'hA5;
            img[b + 2] = 8'h20;
            img[b + 3] = ~i[7:0];
            img[b + 4] = (i == 1) ? 8'h40 : 8'h00;
        end
        b = 6 + 5 * nDef;
        for (int k = 0; k < 5; k++) begin
            if (term) img[b + k] = 8'hFF;
        end
        dmp_host_model_inst.mem = img;
    endtask : build
    task check_sector(input int nDef, input logic [7:0] pad);
        logic [32:0] r;
        int          multi;
        multi = 0;
        repeat (3) @(negedge clk);
        chk("listDone", 16'h0001, {15'h0000, listDone});
        chk("recMonth", 16'h000C, {8'h00, recMonth});
        chk("recDay", 16'h001F, {8'h00, recDay});
        chk("recYear", 16'h0057, {8'h00, recYear});
        chk("recHead", 16'h0003, {8'h00, recHead});
        chk("headerError", {15'h0000, pad != 8'h00}, {15'h0000, headerError});
        chk("defectCount", 16'(nDef), {10'h000, defectCount});
        chk("records", 16'(nDef), 16'(recQ.size()));
        for (int i = 0; i < recQ.size(); i++) begin
            r = recQ[i];
            chk("cylinder", {i[7:0], 8'hA5}, r[31:16]);
            chk("offset", {8'h20, ~i[7:0]}, r[15:0]);
            chk("groupError", {15'h0000, i == 1}, {15'h0000, r[32]});
            // two records on one track make it multiple
            if (i > 0 && r[31:16] == recQ[i-1][31:16]) multi++;
        end
        chk("multiTracks", 16'h0000, 16'(multi));
        recQ.delete();
    endtask : check_sector
    task t_copy;
        logic [15:0] exp [4];
        exp = '{16'h0000, 16'h03FF, 16'h03F7, 16'h0000};
        for (int s = 0; s < 4; s++) begin
            copySel = s[1:0];
            @(negedge clk);
            chk("copyTrack", exp[s], copyTrack);
        end
    endtask : t_copy
    task t_full_slow;
        build(50, 1'b0, 8'h00);
        dmp_host_model_inst.send(1'b1);
        check_sector(50, 8'h00);
    endtask : t_full_slow
    task t_term_fast;
        build(3, 1'b1, 8'h20);
        dmp_host_model_inst.send(1'b0);
        check_sector(3, 8'h20);
        // header check failed, fall back to the next copy
        maxTrack = 16'h0131;
        copySel  = 2'h2;
        @(negedge clk);
        chk("copyTrack", 16'h0129, copyTrack);
        build(3, 1'b1, 8'h00);
        dmp_host_model_inst.send(1'b0);
        check_sector(3, 8'h00);
    endtask : t_term_fast
    // Main sequence
    initial begin
        repeat (5) @(negedge clk);
        reset_n = 1'b1;
        t_copy();
        t_full_slow();
        t_term_fast();
        end_of_test();
    end
endmodule : test_defect_map_parser
`default_nettype wire
